//--- logic/instruction_fetch_pipeline.v
// Behaviour
// - clock divided into four phases Q1-Q4
// - program counter increments once, in Q1
// - fetched word latched from memory in Q4
// - instruction register loads Q1, executes Q2-Q4
// - data read in Q2, write in Q4
// - fetch overlaps execute, one per cycle
// - branch flushes prefetched word as no-operation
// - program memory byte addressed, 2/4-byte instructions
// - low instruction byte at even address
// - counter steps by two, bit zero zero
// - absolute target loads counter bits 20:1
// - relative offset counts single-word instructions
// - add to counter low byte jumps ahead
// - table access uses pointer and latch
// - each table access moves one byte
// - fast call saves, fast return restores three
// - one hidden shadow level, also on interrupt
// - lone second word executes as no-operation
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fetch_pipeline_regs.vh"

module instruction_fetch_pipeline
(
  input  wire        clk,
  input  wire        reset_n,
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output wire [20:0] prog_addr,
  input  wire [15:0] prog_word,
  output wire [20:0] prog_byte_addr,
  output wire        prog_byte_rd,
  output wire        prog_byte_wr,
  output wire [7:0]  prog_byte_wdata,
  input  wire [7:0]  prog_byte_rdata,
  output wire [11:0] data_addr,
  output wire        data_rd,
  output wire        data_wr,
  output wire [7:0]  data_wdata,
  input  wire [7:0]  data_rdata,
  input  wire        int_req,
  output wire [1:0]  phase,
  output wire [15:0] instr_word,
  output wire        flushing
);

  wire        q1;
  wire        q2;
  wire        q3;
  wire        q4;
  reg  [20:0] pc_r;
  reg  [20:0] fetch_addr_r;
  reg  [15:0] fetch_word_r;
  reg  [15:0] ir_r;
  reg         flush_r;
  reg  [1:0]  ctrl_r;
  reg  [7:0]  working_register_r;
  reg  [4:0]  status_r;
  reg  [3:0]  bsr_r;
  reg  [21:0] tptr_r;
  reg  [7:0]  tlat_r;
  reg  [7:0]  operand_r;
  reg  [8:0]  sum_r;
  reg  [11:0] data_addr_r;
  reg  [4:0]  sp_r;
  reg  [20:0] stack_mem [0:30];
  reg         int_meta_r;
  reg         int_sync_r;
  wire [7:0]  sh_working_register;
  wire [4:0]  sh_status;
  wire [3:0]  sh_bsr;
  wire        run;

  // decoded execute-stage controls
  reg         is_goto;
  reg         is_call;
  reg         is_bra;
  reg         is_add_working_to_file;
  reg         is_pcl_add;
  reg         is_return;
  reg         is_return_with_literal;
  reg         is_movlw;
  reg         is_movlb;
  reg         is_tblrd;
  reg         is_tblwt;
  reg         is_second;
  reg         branch;
  reg  [20:0] target;
  reg  [20:0] rel_off;
  reg  [20:0] pop_addr;
  reg  [11:0] next_daddr;
  wire        take_int;
  wire        fast_save;

  assign run = ctrl_r[`CTRL_RUN];

  quad_phase_gen u_phase
  (
    .clk     (clk),
    .reset_n (reset_n),
    .phase   (phase),
    .q1      (q1),
    .q2      (q2),
    .q3      (q3),
    .q4      (q4)
  );

  // interrupt request comes from outside the core clock
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      int_meta_r <= 1'b0;
      int_sync_r <= 1'b0;
    end
    else
    begin
      int_meta_r <= int_req;
      int_sync_r <= int_meta_r;
    end
  end

  always @*
  begin
    is_second  = (ir_r[15:12] == `SECOND_WORD_MARK);
    is_goto    = (ir_r[15:8] == `OP_GOTO);
    is_call    = (ir_r[15:9] == `OP_CALL);
    is_bra     = (ir_r[15:11] == `OP_BRA);
    is_add_working_to_file   = (ir_r[15:10] == `OP_ADD_WORKING_TO_FILE);
    is_pcl_add = is_add_working_to_file && !ir_r[8] && ir_r[9] && (ir_r[7:0] == `PCL_FILE);
    is_return  = (ir_r[15:1] == `OP_RETURN);
    is_return_with_literal   = (ir_r[15:8] == `OP_RETURN_WITH_LITERAL);
    is_movlw   = (ir_r[15:8] == `OP_MOVLW);
    is_movlb   = (ir_r[15:4] == `OP_MOVLB);
    is_tblrd   = (ir_r == `OP_TBLRD);
    is_tblwt   = (ir_r == `OP_TBLWT);
    branch     = !is_second && (is_goto || is_call || is_bra || is_pcl_add || is_return || is_return_with_literal);
    rel_off    = {{9{ir_r[10]}}, ir_r[10:0], 1'b0};
    pop_addr   = (sp_r == `SP_EMPTY) ? `PC_RESET : stack_mem[sp_r - `SP_STEP];
    // second word arrives on prog_word during this Q4
    if (is_goto || is_call)
      target = {prog_word[11:0], ir_r[7:0], 1'b0};
    else if (is_bra)
      target = fetch_addr_r + rel_off;
    else if (is_pcl_add)
      // an odd offset loses its low bit so the target stays on a word boundary
      target = {fetch_addr_r[20:1] + {13'h0000, working_register_r[7:1]}, 1'b0};
    else
      target = pop_addr;
  end

  // program-counter, fetch and pipeline sequencing
  assign take_int  = run && q4 && ctrl_r[`CTRL_INT_EN] && int_sync_r && !branch;
  assign fast_save = run && q4 && ((is_call && ir_r[8]) || take_int);

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      pc_r         <= `PC_RESET;
      fetch_addr_r <= `PC_RESET;
      fetch_word_r <= `NOP_WORD;
      ir_r         <= `NOP_WORD;
      flush_r      <= 1'b1;
      sp_r         <= `SP_EMPTY;
    end
    else if (!run)
      flush_r <= 1'b1;
    else
    begin
      if (q1)
      begin
        fetch_addr_r <= pc_r;
        pc_r         <= pc_r + `PC_STEP;
        ir_r         <= flush_r ? `NOP_WORD : fetch_word_r;
        flush_r      <= 1'b0;
      end
      if (q4)
      begin
        fetch_word_r <= prog_word;
        if (branch)
        begin
          pc_r    <= target;
          flush_r <= 1'b1;
        end
        else if (take_int)
        begin
          pc_r    <= `INT_VECTOR;
          flush_r <= 1'b1;
        end
        if ((is_call || take_int) && sp_r != `SP_FULL)
        begin
          // the word in fetch was discarded, so an interrupt resumes there
          stack_mem[sp_r] <= take_int ? fetch_addr_r : pc_r;
          sp_r            <= sp_r + `SP_STEP;
        end
        else if ((is_return || is_return_with_literal) && sp_r != `SP_EMPTY)
          sp_r <= sp_r - `SP_STEP;
      end
    end
  end

  // data-memory operand path
  always @*
  begin
    if (ir_r[8])
      next_daddr = {bsr_r, ir_r[7:0]};
    else if (ir_r[7])
      next_daddr = {`ACCESS_HI_BANK, ir_r[7:0]};
    else
      next_daddr = {`ACCESS_LO_BANK, ir_r[7:0]};
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      data_addr_r <= 12'h000;
      operand_r   <= 8'h00;
    end
    else
    begin
      if (q2)
        data_addr_r <= next_daddr;
      if (q3)
        operand_r <= data_rdata;
    end
  end

  assign data_addr  = data_addr_r;
  assign data_rd    = run && q2 && is_add_working_to_file && !is_pcl_add;
  assign data_wr    = run && q4 && is_add_working_to_file && !is_pcl_add && ir_r[9];
  assign data_wdata = sum_r[7:0];

  // sum forms in q4 from operand captured one cycle earlier
  always @*
  begin
    sum_r = {1'b0, operand_r} + {1'b0, working_register_r};
  end

  // core registers, shadows and table path
  shadow_copy #(.W(8)) u_sh_working_register
  (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (fast_save),
    .d       (working_register_r),
    .q       (sh_working_register)
  );

  shadow_copy #(.W(5)) u_sh_status
  (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (fast_save),
    .d       (status_r),
    .q       (sh_status)
  );

  shadow_copy #(.W(4)) u_sh_bsr
  (
    .clk     (clk),
    .reset_n (reset_n),
    .load    (fast_save),
    .d       (bsr_r),
    .q       (sh_bsr)
  );

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      ctrl_r   <= `CTRL_RESET;
      working_register_r   <= 8'h00;
      status_r <= `STATUS_RESET;
      bsr_r    <= 4'h0;
      tptr_r   <= 22'h000000;
      tlat_r   <= 8'h00;
    end
    else
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `RA_CTRL:   ctrl_r        <= reg_wdata[1:0];
          `RA_TPTR_L: tptr_r[7:0]   <= reg_wdata;
          `RA_TPTR_H: tptr_r[15:8]  <= reg_wdata;
          `RA_TPTR_U: tptr_r[21:16] <= reg_wdata[5:0];
          `RA_TLAT:   tlat_r        <= reg_wdata;
          `RA_WORKING_REGISTER:   working_register_r        <= reg_wdata;
          `RA_BSR:    bsr_r         <= reg_wdata[3:0];
          default:    ;
        endcase
      end
      if (take_int)
        ctrl_r[`CTRL_INT_EN] <= 1'b0;
      if (run && q4)
      begin
        // core updates win over a software write in the same cycle
        if (is_movlw || is_return_with_literal)
          working_register_r <= ir_r[7:0];
        else if (is_add_working_to_file && !is_pcl_add)
        begin
          if (!ir_r[9])
            working_register_r <= sum_r[7:0];
          status_r[`ST_C] <= sum_r[8];
          status_r[`ST_Z] <= (sum_r[7:0] == 8'h00);
        end
        else if (is_movlb)
          bsr_r <= ir_r[3:0];
        else if (is_return && ir_r[0])
        begin
          working_register_r   <= sh_working_register;
          status_r <= sh_status;
          bsr_r    <= sh_bsr;
        end
        if (is_tblrd)
          tlat_r <= prog_byte_rdata;
      end
    end
  end

  assign prog_byte_addr  = tptr_r[20:0];
  assign prog_byte_rd    = run && q2 && is_tblrd;
  assign prog_byte_wr    = run && q4 && is_tblwt;
  assign prog_byte_wdata = tlat_r;

  // fetch address is always even, one word per fetch
  assign prog_addr  = {fetch_addr_r[20:1], 1'b0};
  assign instr_word = ir_r;
  assign flushing   = flush_r;

  // software read port, data one cycle after the strobe
  always @(posedge clk)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `RA_CTRL:   reg_rdata <= {6'h00, ctrl_r};
        `RA_STATE:  reg_rdata <= {sp_r, flush_r, phase};
        `RA_TPTR_L: reg_rdata <= tptr_r[7:0];
        `RA_TPTR_H: reg_rdata <= tptr_r[15:8];
        `RA_TPTR_U: reg_rdata <= {2'h0, tptr_r[21:16]};
        `RA_TLAT:   reg_rdata <= tlat_r;
        `RA_WORKING_REGISTER:   reg_rdata <= working_register_r;
        `RA_PC_L:   reg_rdata <= {pc_r[7:1], 1'b0};
        `RA_PC_H:   reg_rdata <= pc_r[15:8];
        `RA_PC_U:   reg_rdata <= {3'h0, pc_r[20:16]};
        `RA_BSR:    reg_rdata <= {4'h0, bsr_r};
        default:    reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

endmodule

`default_nettype wire

//--- logic/fetch_pipeline_regs.vh
`ifndef FETCH_PIPELINE_REGS_VH
`define FETCH_PIPELINE_REGS_VH

// quadrature phase codes
`define PH_Q1            2'h0
`define PH_Q2            2'h1
`define PH_Q3            2'h2
`define PH_Q4            2'h3
`define PH_STEP          2'h1

// program counter
`define PC_RESET         21'h000000
`define PC_STEP          21'h000002
`define INT_VECTOR       21'h000008

// instruction encodings
`define NOP_WORD         16'h0000
`define SECOND_WORD_MARK 4'hf
`define OP_GOTO          8'hef
`define OP_CALL          7'h76
`define OP_BRA           5'h1a
`define OP_ADD_WORKING_TO_FILE         6'h09
`define OP_MOVLW         8'h0e
`define OP_RETURN_WITH_LITERAL         8'h0c
`define OP_MOVLB         12'h010
`define OP_RETURN        15'h0009
`define OP_TBLRD         16'h0008
`define OP_TBLWT         16'h000c
`define PCL_FILE         8'hf9
`define ACCESS_HI_BANK   4'hf
`define ACCESS_LO_BANK   4'h0

// return stack
`define SP_EMPTY         5'h00
`define SP_FULL          5'h1f
`define SP_STEP          5'h01

// status bits of the core
`define ST_C             0
`define ST_Z             1
`define STATUS_RESET     5'h00

// software register indices
`define RA_CTRL          4'h0
`define RA_STATE         4'h1
`define RA_TPTR_L        4'h2
`define RA_TPTR_H        4'h3
`define RA_TPTR_U        4'h4
`define RA_TLAT          4'h5
`define RA_WORKING_REGISTER          4'h6
`define RA_PC_L          4'h7
`define RA_PC_H          4'h8
`define RA_PC_U          4'h9
`define RA_BSR           4'ha
`define CTRL_RUN         0
`define CTRL_INT_EN      1
`define CTRL_RESET       2'h0

`endif

//--- logic/quad_phase_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "fetch_pipeline_regs.vh"

module quad_phase_gen
(
  input  wire       clk,
  input  wire       reset_n,
  output wire [1:0] phase,
  output wire       q1,
  output wire       q2,
  output wire       q3,
  output wire       q4
);

  reg [1:0] phase_r;

  always @(posedge clk)
  begin
    if (!reset_n)
      phase_r <= `PH_Q1;
    else
      phase_r <= phase_r + `PH_STEP;
  end

  assign phase = phase_r;
  assign q1    = (phase_r == `PH_Q1);
  assign q2    = (phase_r == `PH_Q2);
  assign q3    = (phase_r == `PH_Q3);
  assign q4    = (phase_r == `PH_Q4);

endmodule

`default_nettype wire

//--- logic/shadow_copy.v
`timescale 1ns/1ps
`default_nettype none

// one-level copy with no software path to it
module shadow_copy
#(
  parameter W = 8
)
(
  input  wire         clk,
  input  wire         reset_n,
  input  wire         load,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] held_r;

  always @(posedge clk)
  begin
    if (!reset_n)
      held_r <= {W{1'b0}};
    else if (load)
      held_r <= d;
  end

  assign q = held_r;

endmodule

`default_nettype wire

//--- verif/instruction_fetch_pipeline_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fetch_checker
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [20:0] prog_addr,
  input wire logic        prog_byte_rd,
  input wire logic        prog_byte_wr,
  input wire logic        data_rd,
  input wire logic        data_wr,
  input wire logic [1:0]  phase,
  input wire logic [15:0] instr_word,
  input wire logic        flushing
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  phase_step_a: assert property ($changed(phase) |-> phase == $past(phase) + 2'h1)
    else $error("phase skipped a step");
  fetch_q1_a: assert property ($changed(prog_addr) |-> $past(phase) == 2'h0)
    else $error("fetch address moved outside Q1");
  addr_even_a: assert property (prog_addr[0] == 1'b0)
    else $error("odd fetch address");
  ir_load_a: assert property ($changed(instr_word) |-> $past(phase) == 2'h0)
    else $error("instruction register loaded outside Q1");
  step_two_a: assert property ($changed(prog_addr) && !$past(flushing) |->
    prog_addr == $past(prog_addr) + 21'h2) else $error("fetch did not advance by two");
  flush_nop_a: assert property ($fell(flushing) |-> instr_word == 16'h0000 && phase == 2'h1)
    else $error("flushed word not replaced by nop");
  operand_rd_a: assert property (data_rd |-> phase == 2'h1)
    else $error("operand read outside Q2");
  dest_wr_a: assert property (data_wr |-> phase == 2'h3)
    else $error("destination write outside Q4");
  table_rd_a: assert property (prog_byte_rd |-> phase == 2'h1 && instr_word == 16'h0008)
    else $error("table read strobe misplaced");
  table_wr_a: assert property (prog_byte_wr |-> phase == 2'h3 && instr_word == 16'h000c)
    else $error("table write strobe misplaced");
  lone_word_a: assert property (instr_word[15:12] == 4'hf |-> !data_rd && !data_wr)
    else $error("lone second word did work");
endmodule
bind instruction_fetch_pipeline fetch_checker chk_i (.clk(clk), .reset_n(reset_n), .prog_addr(prog_addr),
  .prog_byte_rd(prog_byte_rd), .prog_byte_wr(prog_byte_wr), .data_rd(data_rd), .data_wr(data_wr),
  .phase(phase), .instr_word(instr_word), .flushing(flushing));
`default_nettype wire

//--- verif/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_model
(
  input  wire logic        clk,
  input  wire logic [1:0]  phase,
  input  wire logic [20:0] prog_addr,
  output var  logic [15:0] prog_word,
  input  wire logic [20:0] prog_byte_addr,
  input  wire logic        prog_byte_wr,
  input  wire logic [7:0]  prog_byte_wdata,
  output var  logic [7:0]  prog_byte_rdata,
  input  wire logic [11:0] data_addr,
  input  wire logic        data_wr,
  input  wire logic [7:0]  data_wdata,
  output var  logic [7:0]  data_rdata
);
  logic [15:0] pm [0:255];
  logic [7:0]  dm [0:4095];
  logic [15:0] tw;
  initial
  begin
    for (int i = 0; i < 4096; i++)
    begin
      dm[i] = 8'h00;
      if (i < 256) pm[i] = 16'h0000;
    end
  end
  assign prog_word = pm[prog_addr[8:1]];
  assign tw = pm[prog_byte_addr[8:1]];
  assign prog_byte_rdata = prog_byte_addr[0] ? tw[15:8] : tw[7:0];
  // operand only settles in Q3; inverted elsewhere so an early sample shows up
  assign data_rdata = (phase == 2'h2) ? dm[data_addr] : ~dm[data_addr];
  always @(posedge clk)
  begin
    if (data_wr) dm[data_addr] <= data_wdata;
    if (prog_byte_wr && prog_byte_addr[0]) pm[prog_byte_addr[8:1]][15:8] <= prog_byte_wdata;
    if (prog_byte_wr && !prog_byte_addr[0]) pm[prog_byte_addr[8:1]][7:0] <= prog_byte_wdata;
  end
endmodule
`default_nettype wire

//--- verif/instruction_fetch_pipeline_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module instruction_fetch_pipeline_tb_top;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        int_req = 1'b0;
  wire  [7:0]  reg_rdata, prog_byte_wdata, prog_byte_rdata, data_wdata, data_rdata;
  wire  [20:0] prog_addr, prog_byte_addr;
  wire  [15:0] prog_word, instr_word;
  wire  [11:0] data_addr;
  wire  [1:0]  phase;
  wire         prog_byte_rd, prog_byte_wr, data_rd, data_wr, flushing;
  int          n_fail = 0;
  int          samples_checked = 0;
  logic [20:0] fq [$];
  logic [20:0] last_pa = 21'h1;
  logic [20:0] exp_pa [0:14] = '{21'h00, 21'h02, 21'h04, 21'h20, 21'h22, 21'h24, 21'h2a, 21'h2c,
                                 21'h2e, 21'h40, 21'h42, 21'h44, 21'h30, 21'h32, 21'h30};

  instruction_fetch_pipeline uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_addr(prog_addr), .prog_word(prog_word),
    .prog_byte_addr(prog_byte_addr), .prog_byte_rd(prog_byte_rd), .prog_byte_wr(prog_byte_wr),
    .prog_byte_wdata(prog_byte_wdata), .prog_byte_rdata(prog_byte_rdata), .data_addr(data_addr),
    .data_rd(data_rd), .data_wr(data_wr), .data_wdata(data_wdata), .data_rdata(data_rdata),
    .int_req(int_req), .phase(phase), .instr_word(instr_word), .flushing(flushing));
  mem_model mem (.clk(clk), .phase(phase), .prog_addr(prog_addr), .prog_word(prog_word),
    .prog_byte_addr(prog_byte_addr), .prog_byte_wr(prog_byte_wr), .prog_byte_wdata(prog_byte_wdata),
    .prog_byte_rdata(prog_byte_rdata), .data_addr(data_addr), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rdata(data_rdata));

  initial
  begin
    forever #4 clk = ~clk;
  end
  // one entry per instruction cycle that fetched a new address
  always @(negedge clk)
  begin
    if (phase === 2'h0 && prog_addr !== last_pa)
    begin
      fq.push_back(prog_addr);
      last_pa = prog_addr;
    end
  end

  task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        n_fail++;
        $display("ERROR %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
    end
  endtask
  task automatic test_done;
    begin
      if (n_fail == 0 && samples_checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  task automatic test_idle_regs;
    logic [7:0] d;
    begin
      reg_read(4'h1, d);
      chk("state after reset", 21'h05, 21'(d));
      reg_read(4'h7, d);
      chk("counter low after reset", 21'h00, 21'(d));
      reg_read(4'hb, d);
      chk("unmapped index", 21'h00, 21'(d));
      reg_write(4'h6, 8'h5a);
      reg_read(4'h6, d);
      chk("working register", 21'h5a, 21'(d));
    end
  endtask

  task automatic test_program;
    logic [7:0] d;
    int         k;
    begin
      mem.pm[8'h00] = 16'h0e06;
      mem.pm[8'h01] = 16'hef10;
      mem.pm[8'h02] = 16'hf000;
      mem.pm[8'h10] = 16'h0008;
      mem.pm[8'h11] = 16'h26f9;
      mem.pm[8'h12] = 16'h0e11;
      mem.pm[8'h13] = 16'h0e22;
      mem.pm[8'h14] = 16'h0e33;
      mem.pm[8'h15] = 16'h0e44;
      mem.pm[8'h16] = 16'hed20;
      mem.pm[8'h17] = 16'hf000;
      mem.pm[8'h18] = 16'hd7ff;
      mem.pm[8'h20] = 16'h0e77;
      mem.pm[8'h21] = 16'h0013;
      mem.pm[8'h30] = 16'ha5c3;
      reg_write(4'h2, 8'h61);
      reg_write(4'h3, 8'h00);
      reg_write(4'h4, 8'h00);
      reg_write(4'h0, 8'h01);
      for (k = 0; k < 400 && fq.size() < 15; k++) @(posedge clk);
      reg_write(4'h0, 8'h00);
      repeat (8) @(posedge clk);
      for (k = 0; k < 15; k++) chk("fetch address", exp_pa[k], fq[k]);
      reg_read(4'h6, d);
      chk("working register after fast return", 21'h44, 21'(d));
      reg_read(4'h5, d);
      chk("table latch", 21'ha5, 21'(d));
      reg_read(4'h7, d);
      chk("counter low bit", 21'h0, 21'(d[0]));
    end
  endtask

  task automatic test_data_int;
    logic [7:0] d;
    begin
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      reg_read(4'h1, d);
      chk("state after second reset", 21'h05, 21'(d));
      mem.pm[8'h00] = 16'hef10;
      mem.pm[8'h01] = 16'hf000;
      mem.pm[8'h04] = 16'h0e00;
      mem.pm[8'h05] = 16'h0105;
      mem.pm[8'h06] = 16'h0013;
      mem.pm[8'h10] = 16'h0103;
      mem.pm[8'h11] = 16'h0e10;
      mem.pm[8'h12] = 16'h2740;
      mem.pm[8'h13] = 16'h2685;
      mem.pm[8'h14] = 16'h000c;
      mem.pm[8'h15] = 16'hd000;
      mem.pm[8'h16] = 16'hf2ab;
      mem.pm[8'h17] = 16'hec28;
      mem.pm[8'h18] = 16'hf000;
      mem.pm[8'h19] = 16'hd7ff;
      mem.pm[8'h28] = 16'h0c99;
      mem.dm[12'h340] = 8'h25;
      mem.dm[12'hf85] = 8'h01;
      reg_write(4'h2, 8'h01);
      reg_write(4'h3, 8'h01);
      reg_write(4'h5, 8'h3c);
      reg_write(4'h0, 8'h03);
      repeat (150) @(posedge clk);
      int_req <= 1'b1;
      repeat (80) @(posedge clk);
      reg_read(4'h0, d);
      chk("interrupt enable after vector", 21'h01, 21'(d));
      reg_write(4'h0, 8'h00);
      int_req <= 1'b0;
      chk("banked destination write", 21'h35, 21'(mem.dm[12'h340]));
      chk("access destination write", 21'h11, 21'(mem.dm[12'hf85]));
      chk("table write word", 21'h3c00, 21'(mem.pm[8'h80]));
      reg_read(4'h6, d);
      chk("working register after interrupt return", 21'h99, 21'(d));
      reg_read(4'ha, d);
      chk("bank select after interrupt return", 21'h03, 21'(d));
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    test_idle_regs();
    test_program();
    test_data_int();
    test_done();
  end
  initial
  begin
    #40000;
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
